// ### src/cdc_pkg.sv
// shared constants and types for the converter register bank
package cdc_pkg;
	// pointer addresses
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_CAP_H = 8'h01;
	localparam logic [7:0] ADDR_CAP_M = 8'h02;
	localparam logic [7:0] ADDR_CAP_L = 8'h03;
	localparam logic [7:0] ADDR_AUX_H = 8'h04;
	localparam logic [7:0] ADDR_AUX_M = 8'h05;
	localparam logic [7:0] ADDR_AUX_L = 8'h06;
	localparam logic [7:0] ADDR_CAP_SETUP = 8'h07;
	localparam logic [7:0] ADDR_AUX_SETUP = 8'h08;
	localparam logic [7:0] ADDR_EXCITATION_SETUP = 8'h09;
	localparam logic [7:0] ADDR_CONFIG = 8'h0A;
	localparam logic [7:0] ADDR_DAC_A = 8'h0B;
	localparam logic [7:0] ADDR_DAC_B = 8'h0C;
	localparam logic [7:0] ADDR_OFS_H = 8'h0D;
	localparam logic [7:0] ADDR_OFS_L = 8'h0E;
	localparam logic [7:0] ADDR_CGAIN_H = 8'h0F;
	localparam logic [7:0] ADDR_CGAIN_L = 8'h10;
	localparam logic [7:0] ADDR_VGAIN_H = 8'h11;
	localparam logic [7:0] ADDR_VGAIN_L = 8'h12;
	localparam logic [7:0] ADDR_LAST = 8'h12;
	// values after reset
	localparam logic [7:0] RST_STATUS = 8'h07;
	localparam logic [7:0] RST_SETUP = 8'h00;
	localparam logic [7:0] RST_EXC = 8'h03;
	localparam logic [7:0] RST_CONFIG = 8'hA0;
	localparam logic [7:0] RST_DAC = 8'h00;
	localparam logic [7:0] RST_OFS_H = 8'h80;
	localparam logic [7:0] RST_OFS_L = 8'h00;
	localparam logic [23:0] RST_RESULT = 24'h000000;
	// field positions
	localparam int STAT_EXC_BIT = 3;
	localparam int STAT_RDY_BIT = 2;
	localparam int STAT_AUX_BIT = 1;
	localparam int STAT_CAP_BIT = 0;
	localparam int SETUP_EN_BIT = 7;
	localparam int CAP_SEL2_BIT = 6;
	// bus
	localparam logic [6:0] SLAVE_ADDR = 7'h48;
	localparam logic [2:0] BIT_LAST = 3'h7;
	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
	} cdc_bus_state_t;
endpackage

// ### src/cdc_serial_slave.sv
// byte-level two-wire bus slave engine
`timescale 1ns/1ps
module cdc_serial_slave import cdc_pkg::*; (
	// system
	input wire logic i_clk,
	input wire logic i_rst_n,
	// bus pins
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_oe_n,
	// register side
	input wire logic [7:0] i_tx_byte,
	output logic o_start,
	output logic o_stop,
	output logic o_wr_ptr,
	output logic o_wr_data,
	output logic [7:0] o_rx_byte,
	output logic o_rd_load,
	output logic o_rd_ack
);
	cdc_bus_state_t state_r;
	logic scl_q_r;
	logic sda_q_r;
	logic [2:0] cnt_r;
	logic [7:0] sh_r;
	logic drive_r;
	logic first_r;
	logic rd_mode_r;
	logic got8_r;
	logic acked_r;
	wire scl_rise = i_scl & ~scl_q_r;
	wire scl_fall = ~i_scl & scl_q_r;
	wire start_det = i_scl & scl_q_r & sda_q_r & ~i_sda;
	wire stop_det = i_scl & scl_q_r & ~sda_q_r & i_sda;
	wire rx_state = (state_r == ST_ADDR) || (state_r == ST_WR);
	wire addr_hit = (sh_r[7:1] == SLAVE_ADDR);

	assign o_sda_oe_n = ~drive_r;

	always_ff @(posedge i_clk) begin
		scl_q_r <= i_scl;
		sda_q_r <= i_sda;
		o_start <= 1'b0;
		o_stop <= 1'b0;
		o_wr_ptr <= 1'b0;
		o_wr_data <= 1'b0;
		o_rd_load <= 1'b0;
		o_rd_ack <= 1'b0;
		if (!i_rst_n) begin
			state_r <= ST_IDLE;
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
			cnt_r <= 3'h0;
			sh_r <= 8'h00;
			drive_r <= 1'b0;
			first_r <= 1'b0;
			rd_mode_r <= 1'b0;
			got8_r <= 1'b0;
			acked_r <= 1'b0;
			o_rx_byte <= 8'h00;
		end else if (stop_det) begin
			state_r <= ST_IDLE;
			drive_r <= 1'b0;
			o_stop <= 1'b1;
		end else if (start_det) begin
			state_r <= ST_ADDR;
			cnt_r <= 3'h0;
			got8_r <= 1'b0;
			drive_r <= 1'b0;
			o_start <= 1'b1;
		end else begin
			if (rx_state && scl_rise) begin
				sh_r <= {sh_r[6:0], i_sda};
				cnt_r <= cnt_r + 3'h1;
				got8_r <= (cnt_r == BIT_LAST);
			end
			case (state_r)
				ST_ADDR: begin
					if (scl_fall && got8_r) begin
						got8_r <= 1'b0;
						rd_mode_r <= sh_r[0];
						first_r <= 1'b1;
						drive_r <= addr_hit;
						state_r <= addr_hit ? ST_ADDR_ACK : ST_IDLE;
					end
				end
				ST_ADDR_ACK: begin
					if (scl_fall) begin
						cnt_r <= 3'h0;
						if (rd_mode_r) begin
							sh_r <= i_tx_byte;
							drive_r <= ~i_tx_byte[7];
							o_rd_load <= 1'b1;
							state_r <= ST_RD;
						end else begin
							drive_r <= 1'b0;
							state_r <= ST_WR;
						end
					end
				end
				ST_WR: begin
					if (scl_fall && got8_r) begin
						// invalid addresses are acknowledged too
						got8_r <= 1'b0;
						o_rx_byte <= sh_r;
						o_wr_ptr <= first_r;
						o_wr_data <= ~first_r;
						first_r <= 1'b0;
						drive_r <= 1'b1;
						state_r <= ST_WR_ACK;
					end
				end
				ST_WR_ACK: begin
					if (scl_fall) begin
						drive_r <= 1'b0;
						cnt_r <= 3'h0;
						state_r <= ST_WR;
					end
				end
				ST_RD: begin
					if (scl_fall) begin
						if (cnt_r == BIT_LAST) begin
							drive_r <= 1'b0;
							acked_r <= 1'b0;
							state_r <= ST_RD_ACK;
						end else begin
							sh_r <= {sh_r[6:0], 1'b0};
							drive_r <= ~sh_r[6];
							cnt_r <= cnt_r + 3'h1;
						end
					end
				end
				ST_RD_ACK: begin
					if (scl_rise) begin
						acked_r <= ~i_sda;
						o_rd_ack <= ~i_sda;
						if (i_sda) begin
							state_r <= ST_IDLE;
						end
					end else if (scl_fall && acked_r) begin
						cnt_r <= 3'h0;
						sh_r <= i_tx_byte;
						drive_r <= ~i_tx_byte[7];
						o_rd_load <= 1'b1;
						state_r <= ST_RD;
					end
				end
				default: begin
					drive_r <= 1'b0;
				end
			endcase
		end
	end
endmodule

// ### src/cdc_register_map_status.sv
// register bank, address pointer and conversion status of the converter
`timescale 1ns/1ps
module cdc_register_map_status import cdc_pkg::*; (
	// system
	input wire logic i_clk,
	input wire logic i_rst_n,
	// two-wire bus pins
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda,
	output logic o_sda_oe_n,
	// converter results and events
	input wire logic i_cap_done,
	input wire logic [23:0] i_cap_result,
	input wire logic i_aux_done,
	input wire logic [23:0] i_aux_result,
	input wire logic i_exc_fault,
	// factory trims
	input wire logic [15:0] i_cap_gain_trim,
	input wire logic [15:0] i_volt_gain_trim,
	// ready pin
	output logic o_rdy_n,
	// settings to the converter
	output logic [7:0] o_cap_setup,
	output logic [7:0] o_aux_setup,
	output logic [7:0] o_excitation_setup,
	output logic [7:0] o_config,
	output logic [7:0] o_dac_a,
	output logic [7:0] o_dac_b,
	output logic [15:0] o_cap_offset,
	output logic [15:0] o_cap_gain,
	output logic [15:0] o_volt_gain,
	output logic o_second_input_select
);
	logic bus_start;
	logic bus_stop;
	logic wr_ptr;
	logic wr_data;
	logic [7:0] rx_byte;
	logic rd_load;
	logic rd_ack;
	logic [7:0] ptr_r;
	logic [7:0] ptr_nxt;
	logic [7:0] rw_r [ADDR_CAP_SETUP:ADDR_LAST];
	logic [23:0] cap_data_r;
	logic [23:0] aux_data_r;
	logic cap_channel_done_n_r;
	logic cap_channel_done_n_nxt;
	logic aux_channel_done_n_r;
	logic aux_channel_done_n_nxt;
	logic excitation_fault_r;
	logic both_rdy_n_r;
	logic both_rdy_n_nxt;
	logic fresh_cap_r;
	logic fresh_aux_r;
	logic cap_rd_r;
	logic aux_rd_r;
	logic [7:0] rd_map [0:18];
	logic [7:0] tx_byte;
	logic [7:0] status;

	function automatic logic [7:0] rw_reset(input logic [7:0] a);
		case (a)
			ADDR_EXCITATION_SETUP: rw_reset = RST_EXC;
			ADDR_CONFIG: rw_reset = RST_CONFIG;
			ADDR_DAC_A: rw_reset = RST_DAC;
			ADDR_DAC_B: rw_reset = RST_DAC;
			ADDR_OFS_H: rw_reset = RST_OFS_H;
			ADDR_OFS_L: rw_reset = RST_OFS_L;
			default: rw_reset = RST_SETUP;
		endcase
	endfunction

	cdc_serial_slave u_slave (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_scl(i_scl),
		.i_sda(i_sda),
		.o_sda_oe_n(o_sda_oe_n),
		.i_tx_byte(tx_byte),
		.o_start(bus_start),
		.o_stop(bus_stop),
		.o_wr_ptr(wr_ptr),
		.o_wr_data(wr_data),
		.o_rx_byte(rx_byte),
		.o_rd_load(rd_load),
		.o_rd_ack(rd_ack)
	);

	// open-drain: only ever pulls low
	assign o_sda = 1'b0;

	// address pointer
	wire ptr_step = rd_ack | wr_data;
	assign ptr_nxt = bus_stop ? ADDR_STATUS :
		wr_ptr ? rx_byte :
		ptr_step ? ptr_r + 8'h01 :
		ptr_r;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			ptr_r <= ADDR_STATUS;
		end else begin
			ptr_r <= ptr_nxt;
		end
	end

	// writable bank
	wire rw_hit = wr_data && (ptr_r >= ADDR_CAP_SETUP) && (ptr_r <= ADDR_LAST);
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			for (int i = ADDR_CAP_SETUP; i <= ADDR_LAST; i++) begin
				rw_r[i] <= rw_reset(8'(i));
			end
			rw_r[ADDR_CGAIN_H] <= i_cap_gain_trim[15:8];
			rw_r[ADDR_CGAIN_L] <= i_cap_gain_trim[7:0];
			rw_r[ADDR_VGAIN_H] <= i_volt_gain_trim[15:8];
			rw_r[ADDR_VGAIN_L] <= i_volt_gain_trim[7:0];
		end else if (rw_hit) begin
			rw_r[ptr_r] <= rx_byte;
		end
	end

	wire cap_en = rw_r[ADDR_CAP_SETUP][SETUP_EN_BIT];
	wire aux_en = rw_r[ADDR_AUX_SETUP][SETUP_EN_BIT];

	// read tracking; the read ends with the stop
	wire cap_rd_hit = rd_load && (ptr_r >= ADDR_CAP_H) && (ptr_r <= ADDR_CAP_L);
	wire aux_rd_hit = rd_load && (ptr_r >= ADDR_AUX_H) && (ptr_r <= ADDR_AUX_L);
	// a read that starts in this very cycle blocks the update as well
	wire cap_accept = i_cap_done & ~cap_rd_r & ~cap_rd_hit;
	wire aux_accept = i_aux_done & ~aux_rd_r & ~aux_rd_hit;
	wire cap_clear = bus_stop & cap_rd_r;
	wire aux_clear = bus_stop & aux_rd_r;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			cap_rd_r <= 1'b0;
			aux_rd_r <= 1'b0;
		end else begin
			cap_rd_r <= bus_stop ? 1'b0 : (cap_rd_r | cap_rd_hit);
			aux_rd_r <= bus_stop ? 1'b0 : (aux_rd_r | aux_rd_hit);
		end
	end

	// results
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			cap_data_r <= RST_RESULT;
			aux_data_r <= RST_RESULT;
		end else begin
			if (cap_accept) begin
				cap_data_r <= i_cap_result;
			end
			if (aux_accept) begin
				aux_data_r <= i_aux_result;
			end
		end
	end

	// per-channel flags: a new result wins over the clear
	assign cap_channel_done_n_nxt = cap_accept ? 1'b0 :
		cap_clear ? 1'b1 : cap_channel_done_n_r;
	assign aux_channel_done_n_nxt = aux_accept ? 1'b0 :
		aux_clear ? 1'b1 : aux_channel_done_n_r;

	// combined flag when both channels run
	wire pair_done = (fresh_cap_r | cap_accept) & (fresh_aux_r | aux_accept);
	wire both_rise = cap_accept | aux_accept | cap_clear | aux_clear;
	assign both_rdy_n_nxt = pair_done ? 1'b0 : both_rise ? 1'b1 : both_rdy_n_r;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			cap_channel_done_n_r <= RST_STATUS[STAT_CAP_BIT];
			aux_channel_done_n_r <= RST_STATUS[STAT_AUX_BIT];
			both_rdy_n_r <= RST_STATUS[STAT_RDY_BIT];
			excitation_fault_r <= RST_STATUS[STAT_EXC_BIT];
			fresh_cap_r <= 1'b0;
			fresh_aux_r <= 1'b0;
		end else begin
			cap_channel_done_n_r <= cap_channel_done_n_nxt;
			aux_channel_done_n_r <= aux_channel_done_n_nxt;
			both_rdy_n_r <= both_rdy_n_nxt;
			excitation_fault_r <= i_exc_fault;
			fresh_cap_r <= pair_done ? 1'b0 : cap_accept ? 1'b1 : cap_clear ? 1'b0 : fresh_cap_r;
			fresh_aux_r <= pair_done ? 1'b0 : aux_accept ? 1'b1 : aux_clear ? 1'b0 : fresh_aux_r;
		end
	end

	// combined ready selection
	wire rdy_bit = (cap_en && aux_en) ? both_rdy_n_r :
		cap_en ? cap_channel_done_n_r :
		aux_en ? aux_channel_done_n_r :
		1'b1;
	assign status = {4'h0, excitation_fault_r, rdy_bit,
		aux_channel_done_n_r, cap_channel_done_n_r};
	assign o_rdy_n = rdy_bit;

	// read map; the pointer itself has no slot
	assign rd_map[0] = status;
	assign rd_map[1] = cap_data_r[23:16];
	assign rd_map[2] = cap_data_r[15:8];
	assign rd_map[3] = cap_data_r[7:0];
	assign rd_map[4] = aux_data_r[23:16];
	assign rd_map[5] = aux_data_r[15:8];
	assign rd_map[6] = aux_data_r[7:0];
	for (genvar g = ADDR_CAP_SETUP; g <= ADDR_LAST; g++) begin : g_map
		assign rd_map[g] = rw_r[g];
	end
	assign tx_byte = (ptr_r <= ADDR_LAST) ? rd_map[ptr_r[4:0]] : 8'h00;

	// settings out
	assign o_cap_setup = rw_r[ADDR_CAP_SETUP];
	assign o_aux_setup = rw_r[ADDR_AUX_SETUP];
	assign o_excitation_setup = rw_r[ADDR_EXCITATION_SETUP];
	assign o_config = rw_r[ADDR_CONFIG];
	assign o_dac_a = rw_r[ADDR_DAC_A];
	assign o_dac_b = rw_r[ADDR_DAC_B];
	assign o_cap_offset = {rw_r[ADDR_OFS_H], rw_r[ADDR_OFS_L]};
	assign o_cap_gain = {rw_r[ADDR_CGAIN_H], rw_r[ADDR_CGAIN_L]};
	assign o_volt_gain = {rw_r[ADDR_VGAIN_H], rw_r[ADDR_VGAIN_L]};
	assign o_second_input_select = rw_r[ADDR_CAP_SETUP][CAP_SEL2_BIT];

	// checks
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);

	a_status_upper_zero: assert property (status[7:4] == 4'h0)
		else $error("status upper bits not zero");
	a_status_after_reset: assert property ($past(!i_rst_n) |-> status[2:0] == 3'h7)
		else $error("status ready bits not high after reset");
	a_offset_after_reset: assert property ($past(!i_rst_n) |-> o_cap_offset == 16'h8000)
		else $error("offset trim wrong after reset");
	a_gain_trim_load: assert property ($past(!i_rst_n) |->
		o_cap_gain == $past(i_cap_gain_trim) && o_volt_gain == $past(i_volt_gain_trim))
		else $error("gain trims not loaded at reset");
	a_ptr_advance: assert property (rd_ack && !bus_stop |=> ptr_r == $past(ptr_r) + 8'h01)
		else $error("pointer did not advance after read byte");
	a_stop_ptr_zero: assert property (bus_stop |=> ptr_r == ADDR_STATUS)
		else $error("pointer not reset by stop");
	a_cap_flag_set: assert property (i_cap_done && !cap_rd_r && !cap_rd_hit |=>
		!status[STAT_CAP_BIT] && cap_data_r == $past(i_cap_result))
		else $error("cap result not captured");
	a_aux_flag_set: assert property (i_aux_done && !aux_rd_r && !aux_rd_hit |=>
		!status[STAT_AUX_BIT] && aux_data_r == $past(i_aux_result))
		else $error("aux flag not set");
	a_read_freeze: assert property ((cap_rd_r || cap_rd_hit) && !bus_stop |=> $stable(cap_data_r))
		else $error("cap result changed during read");
	a_ro_write_ignored: assert property (wr_data && ptr_r < ADDR_CAP_SETUP && !i_cap_done
		|=> $stable(cap_data_r))
		else $error("read-only result changed by write");
	a_single_mirror: assert property (cap_en && !aux_en |-> status[2] == status[0])
		else $error("combined flag does not mirror cap flag");
	a_both_wait: assert property (cap_en && aux_en && $fell(both_rdy_n_r) |->
		!aux_channel_done_n_r && !cap_channel_done_n_r)
		else $error("combined ready before both channels done");
	a_pin_follows: assert property (o_rdy_n == status[STAT_RDY_BIT])
		else $error("ready pin differs from status bit");
	a_exc_follow: assert property (i_exc_fault |=> status[STAT_EXC_BIT])
		else $error("excitation fault not flagged");
	a_exc_clear: assert property (!i_exc_fault |=> !status[STAT_EXC_BIT])
		else $error("excitation flag stuck");
	a_aux_freeze: assert property ((aux_rd_r || aux_rd_hit) && !bus_stop |=> $stable(aux_data_r))
		else $error("aux result changed during read");
	a_wr_step: assert property (wr_data |=> ptr_r == $past(ptr_r) + 8'h01)
		else $error("pointer did not advance after write byte");
	a_aux_mirror: assert property (aux_en && !cap_en |-> status[2] == status[1])
		else $error("combined flag does not mirror aux flag");
	a_idle_ready: assert property (!cap_en && !aux_en |-> status[STAT_RDY_BIT])
		else $error("ready low with no channel enabled");
	a_ready_release: assert property ((cap_clear || aux_clear) && !cap_accept && !aux_accept
		|=> both_rdy_n_r)
		else $error("combined ready not released after read");

	c_cap_result: cover property (cap_accept ##[1:1000] cap_clear);
	c_read_ack: cover property (rd_load ##[1:1000] rd_ack);
	c_both_ready: cover property (cap_en && aux_en && $fell(both_rdy_n_r));
	c_invalid_write: cover property (wr_data && ptr_r > ADDR_LAST);
	c_aux_only: cover property (aux_en && !cap_en && $fell(o_rdy_n));
endmodule

// ### tb/cdc_host_model.sv
// two-wire bus master that drives the register bank pins
`timescale 1ns/1ps
module cdc_host_model (
	// system
	input wire logic i_clk,
	// bus pins
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda_oe_n
);
	initial begin
		o_scl = 1'b1;
		o_sda_oe_n = 1'b1;
	end
	// every bus step lasts four system clocks; the clock stays high one step and low two
	task automatic tick();
		repeat (4) @(posedge i_clk);
		#1;
	endtask
	// start or repeated start, entered with the clock low or idle
	task automatic start();
		o_sda_oe_n = 1'b1;
		tick();
		o_scl = 1'b1;
		tick();
		o_sda_oe_n = 1'b0;
		tick();
		o_scl = 1'b0;
		tick();
	endtask
	task automatic stop();
		o_sda_oe_n = 1'b0;
		tick();
		o_scl = 1'b1;
		tick();
		o_sda_oe_n = 1'b1;
		tick();
	endtask
	// data moves only while the clock is low, sampled at the end of the high phase
	task automatic bit_io(input logic b, output logic r);
		o_sda_oe_n = b;
		tick();
		o_scl = 1'b1;
		tick();
		r = i_sda;
		o_scl = 1'b0;
		tick();
	endtask
	// eight bits msb first, then the ninth bit
	task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic ack);
		for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
		bit_io(a, ack);
	endtask
endmodule

// ### tb/cdc_register_map_status_tb.sv
// self-checking bench for the converter register bank
`timescale 1ns/1ps
module cdc_register_map_status_tb import cdc_pkg::*; ;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cap_done = 1'b0;
	logic aux_done = 1'b0;
	logic exc_fault = 1'b0;
	logic [23:0] cap_res = 24'h000000;
	logic [23:0] aux_res = 24'h000000;
	logic [15:0] cg_trim = 16'h0000;
	logic [15:0] vg_trim = 16'h0000;
	logic [31:0] seed = 32'h0000005F;
	wire scl;
	wire host_oe_n;
	wire dut_oe_n;
	wire dut_sda;
	wire sda_val;
	wire rdy_n;
	wire sel2;
	wire [7:0] so [0:5];
	wire [15:0] tw [0:2];
	// model state
	logic [7:0] m [0:19];
	logic [7:0] dq [$];
	logic cap_new = 1'b0;
	logic aux_new = 1'b0;
	logic cap_lock = 1'b0;
	logic aux_lock = 1'b0;
	logic exc = 1'b0;
	logic [7:0] q0;
	logic a0;
	int ptr = 0;
	int num_errors = 0;
	int total_checks = 0;
	// pull-up: the line is low while either party pulls it
	assign sda_val = host_oe_n & (dut_oe_n | dut_sda);
	always #4 clk = ~clk;
	cdc_host_model host (.i_clk(clk), .i_sda(sda_val), .o_scl(scl), .o_sda_oe_n(host_oe_n));
	cdc_register_map_status dut (
		.i_clk(clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda_val), .o_sda(dut_sda),
		.o_sda_oe_n(dut_oe_n), .i_cap_done(cap_done), .i_cap_result(cap_res),
		.i_aux_done(aux_done), .i_aux_result(aux_res), .i_exc_fault(exc_fault),
		.i_cap_gain_trim(cg_trim), .i_volt_gain_trim(vg_trim), .o_rdy_n(rdy_n),
		.o_cap_setup(so[0]), .o_aux_setup(so[1]), .o_excitation_setup(so[2]), .o_config(so[3]),
		.o_dac_a(so[4]), .o_dac_b(so[5]), .o_cap_offset(tw[0]), .o_cap_gain(tw[1]),
		.o_volt_gain(tw[2]), .o_second_input_select(sel2));
	function automatic logic [7:0] rb();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	function automatic logic [7:0] stat();
		logic r;
		if (m[7][7] && m[8][7]) r = !(cap_new && aux_new);
		else if (m[7][7]) r = !cap_new;
		else if (m[8][7]) r = !aux_new;
		else r = 1'b1;
		return {4'h0, exc, r, !aux_new, !cap_new};
	endfunction
	task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
		total_checks++;
		if (seen !== exp) begin
			$display("wrong value %s expected %h seen %h", name, exp, seen);
			num_errors++;
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic pin();
		logic [7:0] s;
		s = stat();
		check("ready pin", rdy_n, s[2]);
	endtask
	task automatic outs();
		for (int i = 0; i < 6; i++) check("setting", so[i], m[7 + i]);
		for (int i = 0; i < 3; i++) check("trim", tw[i], {m[13 + 2 * i], m[14 + 2 * i]});
		check("second input", sel2, m[7][6]);
	endtask
	task automatic conv(input logic aux);
		logic [23:0] v;
		v = {rb(), rb(), rb()};
		cap_done = !aux;
		aux_done = aux;
		if (aux) aux_res = v;
		else cap_res = v;
		if (!aux && !cap_lock) begin
			{m[1], m[2], m[3]} = v;
			cap_new = 1'b1;
		end
		if (aux && !aux_lock) begin
			{m[4], m[5], m[6]} = v;
			aux_new = 1'b1;
		end
		cyc(1);
		cap_done = 1'b0;
		aux_done = 1'b0;
		cyc(1);
		pin();
	endtask
	task automatic stop_bus();
		host.stop();
		ptr = 0;
		if (cap_lock) cap_new = 1'b0;
		if (aux_lock) aux_new = 1'b0;
		cap_lock = 1'b0;
		aux_lock = 1'b0;
		pin();
	endtask
	task automatic wr(input int p, input int n);
		logic [7:0] q;
		logic [7:0] d;
		logic a;
		host.start();
		host.xfer(8'h90, 1'b1, q, a);
		host.xfer(p[7:0], 1'b1, q, a);
		ptr = p;
		for (int k = 0; k < n; k++) begin
			d = dq.pop_front();
			host.xfer(d, 1'b1, q, a);
			check("write ack", a, 1'b0);
			if (ptr >= 7 && ptr <= 18) m[ptr] = d;
			ptr++;
		end
		stop_bus();
	endtask
	// a negative pointer reads on from where the last stop left it
	task automatic rd(input int p, input int n, input logic mid);
		logic [7:0] q;
		logic a;
		if (p >= 0) begin
			host.start();
			host.xfer(8'h90, 1'b1, q, a);
			host.xfer(p[7:0], 1'b1, q, a);
			ptr = p;
		end
		host.start();
		host.xfer(8'h91, 1'b1, q, a);
		check("read ack", a, 1'b0);
		for (int k = 0; k < n; k++) begin
			host.xfer(8'hFF, k == n - 1, q, a);
			check("read byte", q, (ptr > 18) ? 8'h00 : (ptr == 0) ? stat() : m[ptr]);
			if (ptr >= 1 && ptr <= 3) cap_lock = 1'b1;
			if (ptr >= 4 && ptr <= 6) aux_lock = 1'b1;
			if (mid && k == 0) conv(1'b0);
			if (k < n - 1) ptr++;
		end
		stop_bus();
	endtask
	task automatic results();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		// about four times the length of a clean run
		#400000;
		num_errors++;
		results();
	end
	initial begin
		cg_trim = {rb(), rb()};
		vg_trim = {rb(), rb()};
		for (int i = 0; i < 20; i++) m[i] = 8'h00;
		m[9] = RST_EXC;
		m[10] = 8'hA0;
		m[13] = 8'h80;
		{m[15], m[16], m[17], m[18]} = {cg_trim, vg_trim};
		repeat (16) @(posedge clk);
		#1;
		rst_n = 1'b1;
		cyc(2);
		outs();
		rd(0, 20, 1'b0);
		// a foreign slave address is not acknowledged
		host.start();
		host.xfer(8'hA0, 1'b1, q0, a0);
		check("foreign ack", a0, 1'b1);
		host.stop();
		for (int i = 0; i < 20; i++) begin
			dq.push_back(rb());
			if (i == 7) dq[7][6] = 1'b0;
		end
		wr(0, 20);
		outs();
		rd(-1, 20, 1'b0);
		dq = '{8'h80, 8'h00};
		wr(7, 2);
		conv(1'b0);
		rd(0, 1, 1'b0);
		rd(1, 3, 1'b1);
		rd(0, 4, 1'b0);
		dq = '{8'h80, 8'h80};
		wr(7, 2);
		conv(1'b0);
		conv(1'b1);
		rd(0, 1, 1'b0);
		rd(4, 3, 1'b0);
		rd(0, 1, 1'b0);
		dq = '{8'h00, 8'h80};
		wr(7, 2);
		conv(1'b1);
		rd(0, 1, 1'b0);
		exc_fault = 1'b1;
		exc = 1'b1;
		cyc(2);
		rd(0, 1, 1'b0);
		exc_fault = 1'b0;
		exc = 1'b0;
		cyc(2);
		rd(0, 1, 1'b0);
		results();
	end
endmodule
